// ===== logic/dram_cpu.sv
`timescale 1ns/1ps
`include "dram_regs.svh"
module dram_cpu (
  input wire logic core_clk,
  input wire logic rst_n,
  dram_if.cpu bus,
  input wire logic [2:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [15:0] regRdata
);
  // ==========================================
  // state
  dram_pkg::dram_cpu_state_t state;
  dram_pkg::dram_cpu_state_t next_state;
  logic [9:0] cmdAddr;
  logic [5:0] cmdData;
  logic [13:0] cmdPc;
  logic [1:0] cmdFlags;
  logic [3:0] result;
  logic [6:1] stat;
  logic [13:0] retPc;
  logic [9:0] next_cmdAddr;
  logic [5:0] next_cmdData;
  logic [13:0] next_cmdPc;
  logic [1:0] next_cmdFlags;
  logic [3:0] next_result;
  logic [6:1] next_stat;
  logic [13:0] next_retPc;
  logic next_req;
  dram_pkg::dram_op_t next_op;
  logic [15:0] next_regRdata;

  // ==========================================
  // next values
  always_comb begin
    next_state = state;
    next_cmdAddr = cmdAddr;
    next_cmdData = cmdData;
    next_cmdPc = cmdPc;
    next_cmdFlags = cmdFlags;
    next_result = result;
    next_stat = stat;
    next_retPc = retPc;
    next_req = 1'b0;
    next_op = bus.op;
    next_regRdata = 16'h0000;
    if (regWr) begin
      case (regAddr)
        `DRAM_CPU_ADDR: next_cmdAddr = regWdata[9:0];
        `DRAM_CPU_DATA: next_cmdData = regWdata[5:0];
        `DRAM_CPU_PC: next_cmdPc = regWdata[13:0];
        `DRAM_CPU_FLAGS: next_cmdFlags = regWdata[1:0];
        `DRAM_CPU_CMD: begin
          // commands while busy are dropped
          if (state == dram_pkg::DRAM_CPU_IDLE) begin
            next_op = dram_pkg::dram_op_t'(regWdata[3:0]);
            if (dram_pkg::dramLegal(next_op, cmdAddr, cmdData[5:4])) begin
              // address passes unchanged; bank select must be loaded first
              next_req = 1'b1;
              next_state = dram_pkg::DRAM_CPU_WAIT;
              next_stat = 6'h00;
            end else begin
              next_stat = 6'h20;
            end
          end
        end
        default: begin
        end
      endcase
    end
    case (state)
      dram_pkg::DRAM_CPU_IDLE: begin
      end
      dram_pkg::DRAM_CPU_WAIT: begin
        if (bus.rvalid) begin
          next_state = dram_pkg::DRAM_CPU_IDLE;
          next_result = bus.rdata;
          // flags valid only after interrupt return
          next_stat = {1'b0, bus.retCa, bus.retSt, bus.flagsRestored, bus.bitFlag, bus.err};
          next_retPc = bus.retPc;
        end
      end
      default: begin
        next_state = dram_pkg::DRAM_CPU_IDLE;
      end
    endcase
    if (regRd) begin
      case (regAddr)
        `DRAM_CPU_ADDR: next_regRdata = {6'h00, cmdAddr};
        `DRAM_CPU_DATA: next_regRdata = {10'h000, cmdData};
        `DRAM_CPU_PC: next_regRdata = {2'h0, cmdPc};
        `DRAM_CPU_FLAGS: next_regRdata = {14'h0000, cmdFlags};
        `DRAM_CPU_STAT: next_regRdata = {9'h000, stat, state == dram_pkg::DRAM_CPU_WAIT};
        `DRAM_CPU_RESULT: next_regRdata = {12'h000, result};
        `DRAM_CPU_RETPC: next_regRdata = {2'h0, retPc};
        default: next_regRdata = 16'h0000;
      endcase
    end
  end

  // ==========================================
  // registers
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state <= dram_pkg::DRAM_CPU_IDLE;
      cmdAddr <= 10'h000;
      cmdData <= 6'h00;
      cmdPc <= 14'h0000;
      cmdFlags <= 2'h0;
      result <= 4'h0;
      stat <= 6'h00;
      retPc <= 14'h0000;
      regRdata <= 16'h0000;
      bus.req <= 1'b0;
      bus.op <= dram_pkg::DRAM_READ;
      bus.addr <= 10'h000;
      bus.wdata <= 4'h0;
      bus.bitSel <= 2'h0;
      bus.pc <= 14'h0000;
      bus.st <= 1'b0;
      bus.ca <= 1'b0;
    end else begin
      state <= next_state;
      cmdAddr <= next_cmdAddr;
      cmdData <= next_cmdData;
      cmdPc <= next_cmdPc;
      cmdFlags <= next_cmdFlags;
      result <= next_result;
      stat <= next_stat;
      retPc <= next_retPc;
      regRdata <= next_regRdata;
      bus.req <= next_req;
      bus.op <= next_op;
      bus.addr <= cmdAddr;
      bus.wdata <= cmdData[3:0];
      bus.bitSel <= cmdData[5:4];
      bus.pc <= cmdPc;
      bus.st <= cmdFlags[1];
      bus.ca <= cmdFlags[0];
    end
  end
endmodule

// ===== logic/dram_device.sv
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
`include "dram_regs.svh"
module dram_device (
  input wire logic core_clk,
  input wire logic rst_n,
  dram_if.dev bus,
  input wire logic [6:0] intEvent,
  output logic intTake,
  output logic [2:0] intVector,
  output logic [127:0] segData
);
  // ==========================================
  // helpers
  // banks other than zero share one extra copy of the banked window
  function automatic logic [10:0] physIdx(logic [9:0] a, logic [3:0] bank);
    logic [9:0] off;
    off = a - `DRAM_BANKED_FIRST;
    physIdx = {1'b0, a};
    if (a >= `DRAM_BANKED_FIRST && a <= `DRAM_BANKED_LAST && bank != 4'h0) begin
      physIdx = `DRAM_EXTRA_BASE + {1'b0, off};
    end
  endfunction

  function automatic logic isMapped(logic [9:0] a);
    isMapped = (a <= `DRAM_DISPLAY_LAST) || (a >= `DRAM_BANKED_FIRST && a <= `DRAM_DIRECT_LAST) ||
      (a >= `DRAM_STACK_FIRST);
  endfunction

  // ==========================================
  // state
  logic [3:0] mem [`DRAM_MEM_DIGITS];
  logic [4:0] sp;
  logic [4:0] next_sp;
  logic [3:0] next_int [4];
  logic wrEn;
  logic [10:0] wrIdx;
  logic [3:0] wrData;
  logic pushEn;
  logic [9:0] pushBase;
  logic [3:0] pushNib [4];
  logic next_rvalid;
  logic [3:0] next_rdata;
  logic next_bitFlag;
  logic next_err;
  logic [13:0] next_retPc;
  logic next_retSt;
  logic next_retCa;
  logic next_flagsRestored;
  logic next_intTake;
  logic [2:0] next_intVector;
  logic [10:0] idx;
  logic [3:0] cur;
  logic [3:0] modNib;
  logic [10:0] mrIdx;
  logic [9:0] popBase;
  logic legal;
  logic mapped;

  // ==========================================
  // next values
  always_comb begin
    idx = physIdx(bus.addr, mem[`DRAM_RAM_BANK_SELECT]);
    cur = mem[idx];
    mapped = isMapped(bus.addr);
    legal = dram_pkg::dramLegal(bus.op, bus.addr, bus.bitSel);
    // memreg digit by low address bits
    mrIdx = {1'b0, `DRAM_MEMREG_FIRST} + {7'h00, bus.addr[3:0]};
    pushBase = `DRAM_STACK_FIRST + {4'h0, sp[3:0], 2'b00};
    popBase = `DRAM_STACK_FIRST + {4'h0, sp[3:0] - 4'h1, 2'b00};
    modNib = cur;
    if (bus.op == dram_pkg::DRAM_BIT_SET) begin
      modNib[bus.bitSel] = 1'b1;
    end else if (bus.op == dram_pkg::DRAM_BIT_CLEAR) begin
      modNib[bus.bitSel] = 1'b0;
    end
    // stack pointer clear is an action, never stored
    if (bus.addr == 10'h000) begin
      modNib[`DRAM_STACK_POINTER_CLEAR_BIT] = 1'b0;
    end
    for (int k = 0; k < 4; k++) begin
      next_int[k] = mem[k];
    end
    next_sp = sp;
    next_rvalid = bus.req;
    next_rdata = 4'h0;
    next_bitFlag = 1'b0;
    next_err = 1'b0;
    next_retPc = bus.retPc;
    next_retSt = bus.retSt;
    next_retCa = bus.retCa;
    next_flagsRestored = 1'b0;
    wrEn = 1'b0;
    wrIdx = idx;
    wrData = bus.wdata;
    pushEn = 1'b0;
    // saved digits: pc low first, flags on top
    pushNib[0] = bus.pc[3:0];
    pushNib[1] = bus.pc[7:4];
    pushNib[2] = bus.pc[11:8];
    pushNib[3] = {bus.st, bus.ca, bus.pc[13:12]};
    if (bus.req) begin
      if (!legal) begin
        next_err = 1'b1;
      end else begin
        case (bus.op)
          dram_pkg::DRAM_READ: begin
            next_rdata = mapped ? cur : 4'h0;
          end
          dram_pkg::DRAM_WRITE: begin
            wrEn = mapped;
          end
          dram_pkg::DRAM_BIT_SET, dram_pkg::DRAM_BIT_CLEAR: begin
            if (bus.addr <= `DRAM_INT_LAST) begin
              next_int[bus.addr[1:0]] = modNib;
            end else begin
              wrEn = mapped;
              wrData = modNib;
            end
            if (bus.op == dram_pkg::DRAM_BIT_SET && bus.addr == 10'h000 &&
                bus.bitSel == 2'(`DRAM_STACK_POINTER_CLEAR_BIT)) begin
              next_sp = 5'h00;
            end
          end
          dram_pkg::DRAM_BIT_TEST: begin
            next_bitFlag = cur[bus.bitSel];
          end
          dram_pkg::DRAM_LOAD_ACC_FROM_MEMREG: begin
            next_rdata = mem[mrIdx];
          end
          dram_pkg::DRAM_EXCHANGE_MEMREG_ACC: begin
            next_rdata = mem[mrIdx];
            wrEn = 1'b1;
            wrIdx = mrIdx;
          end
          dram_pkg::DRAM_CALL, dram_pkg::DRAM_INT_ENTRY: begin
            if (sp == `DRAM_STACK_LEVELS) begin
              next_err = 1'b1;
            end else begin
              pushEn = 1'b1;
              next_sp = sp + 5'h01;
              if (bus.op == dram_pkg::DRAM_INT_ENTRY) begin
                next_int[0][`DRAM_GLOBAL_INT_ENABLE_BIT] = 1'b0;
              end
            end
          end
          dram_pkg::DRAM_PLAIN_RETURN, dram_pkg::DRAM_INTERRUPT_RETURN: begin
            if (sp == 5'h00) begin
              next_err = 1'b1;
            end else begin
              next_sp = sp - 5'h01;
              // pc always, flags only on interrupt return
              next_retPc = {mem[popBase + 10'h3][1:0], mem[popBase + 10'h2], mem[popBase + 10'h1],
                mem[popBase]};
              if (bus.op == dram_pkg::DRAM_INTERRUPT_RETURN) begin
                next_retSt = mem[popBase + 10'h3][3];
                next_retCa = mem[popBase + 10'h3][2];
                next_flagsRestored = 1'b1;
              end
            end
          end
          default: begin
            next_err = 1'b1;
          end
        endcase
      end
    end
    // sources latch request flags; set wins over a same-cycle clear
    for (int i = 0; i < `DRAM_INT_SOURCES; i++) begin
      if (intEvent[i]) begin
        next_int[(i + 1) >> 1][(i == 0) ? 2 : (((i - 1) & 1) != 0 ? 2 : 0)] = 1'b1;
      end
    end
    next_intTake = 1'b0;
    next_intVector = 3'h0;
    // lowest source wins among request, unmasked, enabled
    for (int i = `DRAM_INT_SOURCES - 1; i >= 0; i--) begin
      if (mem[(i + 1) >> 1][(i == 0) ? 2 : (((i - 1) & 1) != 0 ? 2 : 0)] &&
          !mem[(i + 1) >> 1][(i == 0) ? 3 : (((i - 1) & 1) != 0 ? 3 : 1)] &&
          mem[0][`DRAM_GLOBAL_INT_ENABLE_BIT]) begin
        next_intTake = 1'b1;
        next_intVector = 3'(i);
      end
    end
  end

  // ==========================================
  // registers
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < `DRAM_MEM_DIGITS; i++) begin
        mem[i] <= 4'h0;
      end
      sp <= 5'h00;
      bus.rvalid <= 1'b0;
      bus.rdata <= 4'h0;
      bus.bitFlag <= 1'b0;
      bus.err <= 1'b0;
      bus.retPc <= 14'h0000;
      bus.retSt <= 1'b0;
      bus.retCa <= 1'b0;
      bus.flagsRestored <= 1'b0;
      intTake <= 1'b0;
      intVector <= 3'h0;
    end else begin
      if (wrEn) begin
        mem[wrIdx] <= wrData;
      end
      for (int k = 0; k < 4; k++) begin
        mem[k] <= next_int[k];
      end
      if (pushEn) begin
        for (int k = 0; k < 4; k++) begin
          mem[{1'b0, pushBase} + 11'(k)] <= pushNib[k];
        end
      end
      sp <= next_sp;
      bus.rvalid <= next_rvalid;
      bus.rdata <= next_rdata;
      bus.bitFlag <= next_bitFlag;
      bus.err <= next_err;
      bus.retPc <= next_retPc;
      bus.retSt <= next_retSt;
      bus.retCa <= next_retCa;
      bus.flagsRestored <= next_flagsRestored;
      intTake <= next_intTake;
      intVector <= next_intVector;
    end
  end

  // display digits straight to segment lines, all 32 at once
  always_comb begin
    for (int d = 0; d < `DRAM_DISPLAY_DIGITS; d++) begin
      segData[d * 4 +: 4] = mem[`DRAM_DISPLAY_FIRST + d];
    end
  end
endmodule

// ===== logic/dram_if.sv
`timescale 1ns/1ps
interface dram_if;
  logic req;
  dram_pkg::dram_op_t op;
  logic [9:0] addr;
  logic [3:0] wdata;
  logic [1:0] bitSel;
  logic [13:0] pc;
  logic st;
  logic ca;
  logic rvalid;
  logic [3:0] rdata;
  logic bitFlag;
  logic err;
  logic [13:0] retPc;
  logic retSt;
  logic retCa;
  logic flagsRestored;

  modport dev (
    input req, op, addr, wdata, bitSel, pc, st, ca,
    output rvalid, rdata, bitFlag, err, retPc, retSt, retCa, flagsRestored
  );
  modport cpu (
    output req, op, addr, wdata, bitSel, pc, st, ca,
    input rvalid, rdata, bitFlag, err, retPc, retSt, retCa, flagsRestored
  );
endinterface

// ===== logic/dram_pkg.sv
package dram_pkg;
`include "dram_regs.svh"

  typedef enum logic [3:0] {
    DRAM_READ = 4'h0,
    DRAM_WRITE = 4'h1,
    DRAM_BIT_SET = 4'h2,
    DRAM_BIT_CLEAR = 4'h3,
    DRAM_BIT_TEST = 4'h4,
    DRAM_LOAD_ACC_FROM_MEMREG = 4'h5,
    DRAM_EXCHANGE_MEMREG_ACC = 4'h6,
    DRAM_CALL = 4'h7,
    DRAM_INT_ENTRY = 4'h8,
    DRAM_PLAIN_RETURN = 4'h9,
    DRAM_INTERRUPT_RETURN = 4'hA
  } dram_op_t;

  typedef enum logic [1:0] {
    DRAM_CPU_IDLE = 2'b00,
    DRAM_CPU_WAIT = 2'b01
  } dram_cpu_state_t;

  // both ends refuse the same control and special register accesses, so the check lives here
  function automatic logic dramLegal(dram_op_t op, logic [9:0] addr, logic [1:0] bitSel);
    logic isBit;
    logic ctlArea;
    logic specArea;
    isBit = (op == DRAM_BIT_SET) || (op == DRAM_BIT_CLEAR) || (op == DRAM_BIT_TEST);
    ctlArea = (addr <= `DRAM_INT_LAST) || (addr >= `DRAM_FLAG_FIRST && addr <= `DRAM_FLAG_LAST);
    specArea = !ctlArea && addr >= `DRAM_SPEC_FIRST && addr <= `DRAM_SPEC_LAST;
    dramLegal = 1'b1;
    // control bits only by bit ops
    if (ctlArea && (op == DRAM_READ || op == DRAM_WRITE)) begin
      dramLegal = 1'b0;
    end
    if (specArea && isBit) begin
      dramLegal = (op != DRAM_BIT_TEST) &&
        (addr == `DRAM_DISPLAY_CONTROL || (addr == `DRAM_TONE_OUTPUT_MODE && bitSel == `DRAM_TONE_BIT));
    end
  endfunction
endpackage

// ===== logic/dram_regs.svh
`ifndef DRAM_REGS_SVH
`define DRAM_REGS_SVH

// ==========================================
// address map
`define DRAM_INT_LAST 10'h003
`define DRAM_SPEC_FIRST 10'h004
`define DRAM_FLAG_FIRST 10'h020
`define DRAM_FLAG_LAST 10'h023
`define DRAM_SPEC_LAST 10'h03F
`define DRAM_DISPLAY_CONTROL 10'h02C
`define DRAM_TONE_OUTPUT_MODE 10'h02E
`define DRAM_TONE_BIT 2'h3
`define DRAM_RAM_BANK_SELECT 10'h03F
`define DRAM_MEMREG_FIRST 10'h040
`define DRAM_DISPLAY_FIRST 10'h050
`define DRAM_DISPLAY_LAST 10'h06F
`define DRAM_BANKED_FIRST 10'h090
`define DRAM_BANKED_LAST 10'h25F
`define DRAM_DIRECT_LAST 10'h38F
`define DRAM_STACK_FIRST 10'h3C0
// ==========================================
// interrupt control bits in the nibble at 000
`define DRAM_GLOBAL_INT_ENABLE_BIT 0
`define DRAM_STACK_POINTER_CLEAR_BIT 1
`define DRAM_INT_SOURCES 7
// ==========================================
// storage: banked window repeated above the plain map
`define DRAM_BANKED_DIGITS 464
`define DRAM_MEM_DIGITS 1488
`define DRAM_EXTRA_BASE 11'h400
`define DRAM_STACK_LEVELS 5'h10
`define DRAM_DISPLAY_DIGITS 32
// ==========================================
// controller register offsets
`define DRAM_CPU_ADDR 3'h0
`define DRAM_CPU_DATA 3'h1
`define DRAM_CPU_PC 3'h2
`define DRAM_CPU_FLAGS 3'h3
`define DRAM_CPU_CMD 3'h4
`define DRAM_CPU_STAT 3'h5
`define DRAM_CPU_RESULT 3'h6
`define DRAM_CPU_RETPC 3'h7
`endif

// ===== test/dram_link_asserts.sv
`timescale 1ns/1ps
module dram_link_asserts (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic req,
  input wire dram_pkg::dram_op_t op,
  input wire logic [9:0] addr,
  input wire logic [1:0] bitSel,
  input wire logic rvalid,
  input wire logic err,
  input wire logic [13:0] retPc,
  input wire logic retSt,
  input wire logic retCa,
  input wire logic flagsRestored
);
  // ==========================================
  // request classes
  wire logic plainOp = (op == dram_pkg::DRAM_READ) || (op == dram_pkg::DRAM_WRITE);
  wire logic bitOp = (op == dram_pkg::DRAM_BIT_SET) || (op == dram_pkg::DRAM_BIT_CLEAR) ||
    (op == dram_pkg::DRAM_BIT_TEST);
  wire logic intArea = addr <= 10'h003;
  wire logic flagArea = addr >= 10'h020 && addr <= 10'h023;
  wire logic specArea = addr >= 10'h004 && addr <= 10'h03F && !flagArea;
  wire logic bitOk = op != dram_pkg::DRAM_BIT_TEST && (addr == 10'h02C || (addr == 10'h02E && bitSel == 2'h3));
  wire logic popOp = (op == dram_pkg::DRAM_PLAIN_RETURN) || (op == dram_pkg::DRAM_INTERRUPT_RETURN);

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  // ==========================================
  // link answers and issued requests
  int_plain_refused_a: assert property (req && plainOp && intArea |=> rvalid && err)
    else $error("plain access to interrupt bits not refused");
  flag_plain_refused_a: assert property (req && plainOp && flagArea |=> rvalid && err)
    else $error("plain access to flag bits not refused");
  spec_bit_refused_a: assert property (req && bitOp && specArea && !bitOk |=> err)
    else $error("bit access to special register not refused");
  spec_bit_taken_a: assert property (req && bitOp && specArea && bitOk |=> rvalid && !err)
    else $error("allowed bit access refused");
  spec_plain_taken_a: assert property (req && plainOp && specArea |=> !err)
    else $error("special register access refused");
  data_ram_taken_a: assert property (req && plainOp && addr >= 10'h090 |=> rvalid && !err)
    else $error("data area access refused");
  plain_ret_flags_a: assert property (req && op == dram_pkg::DRAM_PLAIN_RETURN |=>
    !flagsRestored && $stable(retSt) && $stable(retCa))
    else $error("plain return touched flags");
  int_ret_flags_a: assert property (req && op == dram_pkg::DRAM_INTERRUPT_RETURN |=>
    rvalid && (flagsRestored == !err))
    else $error("interrupt return flags wrong");
  retpc_hold_a: assert property (!(req && popOp) |=> $stable(retPc))
    else $error("return pc moved without pop");
  ctl_plain_blocked_a: assert property (req |-> !(plainOp && (intArea || flagArea)))
    else $error("plain access to control bits issued");
  spec_bit_blocked_a: assert property (req |-> !(bitOp && specArea && !bitOk))
    else $error("forbidden bit access issued");
endmodule

// ===== test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic core_clk;
  logic rst_n;
  logic [2:0] regAddr;
  logic [15:0] regWdata;
  logic regWr;
  logic regRd;
  logic [15:0] regRdata;
  logic [6:0] intEvent;
  logic intTake;
  logic [2:0] intVector;
  logic [127:0] segData;
  logic [15:0] got;
  logic [9:0] ctl [4];
  int err_count;
  int cmp_count;
  int i;

  dram_if u_dram_if ();
  dram_device u_dram_device (.core_clk(core_clk), .rst_n(rst_n), .bus(u_dram_if), .intEvent(intEvent),
    .intTake(intTake), .intVector(intVector), .segData(segData));
  dram_cpu u_dram_cpu (.core_clk(core_clk), .rst_n(rst_n), .bus(u_dram_if), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata));
  dram_link_asserts u_dram_link_asserts (.core_clk(core_clk), .rst_n(rst_n), .req(u_dram_if.req),
    .op(u_dram_if.op), .addr(u_dram_if.addr), .bitSel(u_dram_if.bitSel), .rvalid(u_dram_if.rvalid),
    .err(u_dram_if.err), .retPc(u_dram_if.retPc), .retSt(u_dram_if.retSt), .retCa(u_dram_if.retCa),
    .flagsRestored(u_dram_if.flagsRestored));

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // ==========================================
  // register port tasks
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a);
    @(posedge core_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1 got = regRdata;
  endtask

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic conclude();
    $display("errors %0d comparisons %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // launches one link operation and leaves the final status in got
  task automatic run(input logic [3:0] o, input logic [9:0] a, input logic [5:0] d);
    int n;
    wr(3'h0, {6'h00, a});
    wr(3'h1, {10'h000, d});
    wr(3'h4, {12'h000, o});
    for (n = 0; n < 20; n++) begin
      rd(3'h5);
      if (got[0] === 1'b0) break;
    end
    if (n == 20) begin
      err_count++;
      conclude();
    end
  endtask

  task automatic mread(input logic [9:0] a);
    run(dram_pkg::DRAM_READ, a, 6'h00);
    rd(3'h6);
  endtask

  task automatic mwr(input logic [9:0] a, input logic [3:0] d);
    run(dram_pkg::DRAM_WRITE, a, {2'h0, d});
  endtask

  // ==========================================
  // main sequence
  initial begin
    rst_n = 1'b0;
    regAddr = 3'h0;
    regWdata = 16'h0000;
    regWr = 1'b0;
    regRd = 1'b0;
    intEvent = 7'h00;
    err_count = 0;
    cmp_count = 0;
    ctl = '{10'h000, 10'h003, 10'h020, 10'h023};
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(3'h7);
    chk(got, 16'h0000);
    mwr(10'h03F, 4'h0);
    mwr(10'h090, 4'h5);
    mwr(10'h260, 4'h3);
    mwr(10'h03F, 4'h1);
    mwr(10'h090, 4'hA);
    mread(10'h03F);
    chk(got, 16'h0001);
    mread(10'h090);
    chk(got, 16'h000A);
    mread(10'h260);
    chk(got, 16'h0003);
    mwr(10'h03F, 4'h0);
    mread(10'h090);
    chk(got, 16'h0005);
    for (i = 0; i < 8; i++) begin
      run(i[0] ? dram_pkg::DRAM_WRITE : dram_pkg::DRAM_READ, ctl[i >> 1], 6'h00);
      chk(got, 16'h0040);
    end
    run(dram_pkg::DRAM_BIT_SET, 10'h02C, 6'h20);
    mread(10'h02C);
    chk(got, 16'h0004);
    run(dram_pkg::DRAM_BIT_SET, 10'h02E, 6'h30);
    mread(10'h02E);
    chk(got, 16'h0008);
    run(dram_pkg::DRAM_BIT_CLEAR, 10'h02C, 6'h20);
    mread(10'h02C);
    chk(got, 16'h0000);
    run(dram_pkg::DRAM_BIT_SET, 10'h02E, 6'h10);
    chk(got, 16'h0040);
    run(dram_pkg::DRAM_BIT_TEST, 10'h02C, 6'h20);
    chk(got, 16'h0040);
    run(dram_pkg::DRAM_BIT_CLEAR, 10'h010, 6'h00);
    chk(got, 16'h0040);
    mwr(10'h050, 4'h9);
    mwr(10'h06F, 4'h6);
    chk({12'h000, segData[3:0]}, 16'h0009);
    chk({12'h000, segData[127:124]}, 16'h0006);
    mwr(10'h045, 4'h7);
    run(dram_pkg::DRAM_LOAD_ACC_FROM_MEMREG, 10'h045, 6'h00);
    rd(3'h6);
    chk(got, 16'h0007);
    run(dram_pkg::DRAM_EXCHANGE_MEMREG_ACC, 10'h045, 6'h03);
    rd(3'h6);
    chk(got, 16'h0007);
    mread(10'h045);
    chk(got, 16'h0003);
    // ==========================================
    // interrupt gating: ext0 request is source 1
    run(dram_pkg::DRAM_BIT_SET, 10'h000, 6'h00);
    @(posedge core_clk);
    intEvent <= 7'h02;
    @(posedge core_clk);
    intEvent <= 7'h00;
    run(dram_pkg::DRAM_BIT_TEST, 10'h001, 6'h00);
    chk(got, 16'h0004);
    chk({12'h000, intTake, intVector}, 16'h0009);
    run(dram_pkg::DRAM_BIT_SET, 10'h001, 6'h10);
    chk({15'h0000, intTake}, 16'h0000);
    run(dram_pkg::DRAM_BIT_CLEAR, 10'h001, 6'h10);
    chk({12'h000, intTake, intVector}, 16'h0009);
    run(dram_pkg::DRAM_BIT_CLEAR, 10'h001, 6'h00);
    chk({15'h0000, intTake}, 16'h0000);
    // ==========================================
    // stack save and restore
    mwr(10'h3FF, 4'hA);
    mread(10'h3FF);
    chk(got, 16'h000A);
    wr(3'h2, 16'h1234);
    wr(3'h3, 16'h0003);
    rd(3'h2);
    chk(got, 16'h1234);
    rd(3'h3);
    chk(got, 16'h0003);
    run(dram_pkg::DRAM_CALL, 10'h000, 6'h00);
    chk(got, 16'h0000);
    for (i = 0; i < 4; i++) begin
      mread(10'h3C0 + 10'(i));
      chk(got, i == 3 ? 16'h000D : 16'(4 - i));
    end
    run(dram_pkg::DRAM_PLAIN_RETURN, 10'h000, 6'h00);
    chk(got, 16'h0000);
    rd(3'h7);
    chk(got, 16'h1234);
    run(dram_pkg::DRAM_INT_ENTRY, 10'h000, 6'h00);
    run(dram_pkg::DRAM_BIT_TEST, 10'h000, 6'h00);
    chk(got, 16'h0000);
    run(dram_pkg::DRAM_INTERRUPT_RETURN, 10'h000, 6'h00);
    chk(got, 16'h0038);
    for (i = 0; i < 17; i++) begin
      run(dram_pkg::DRAM_CALL, 10'h000, 6'h00);
      chk(got, i == 16 ? 16'h0032 : 16'h0030);
    end
    mread(10'h3FC);
    chk(got, 16'h0004);
    mread(10'h3FF);
    chk(got, 16'h000D);
    run(dram_pkg::DRAM_BIT_SET, 10'h000, 6'h10);
    run(dram_pkg::DRAM_PLAIN_RETURN, 10'h000, 6'h00);
    chk(got, 16'h0032);
    run(4'hB, 10'h000, 6'h00);
    chk(got, 16'h0032);
    conclude();
  end
endmodule
